//--- iocts_pkg.sv
package iocts_pkg;

   // apb register byte offsets
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_BURST  = 12'h008;
   localparam logic [11:0] ADDR_CAPT   = 12'h00c;

   // control register fields
   localparam int CTRL_DDR_BIT    = 0;
   localparam int CTRL_LATCH_BIT  = 1;
   localparam int CTRL_BYPASS_BIT = 2;
   localparam int CTRL_ARM_BIT    = 3;
   localparam int CTRL_WIDTH      = 3;

   // status register fields
   localparam int ST_POL_BIT    = 0;
   localparam int ST_ACTIVE_BIT = 1;
   localparam int ST_ARMED_BIT  = 2;
   localparam int ST_MISS_BIT   = 3;
   localparam int ST_DET_LSB    = 8;
   localparam int ST_BEAT_LSB   = 16;

   // reset values
   localparam logic [2:0] CTRL_RESET  = 3'h0;
   localparam logic [7:0] BURST_RESET = 8'h08;

   // link clock rising edges allowed between arming and the preamble
   localparam logic [7:0] PREAMBLE_WAIT_EDGES = 8'h40;

   localparam int ELEMENTS = 2;

   typedef enum logic [1:0] {
      RD_IDLE,
      RD_ARMED,
      RD_BURST
   } iocts_read_type;

endpackage

//--- iocts_tri_if.sv
`timescale 1ns/1ps
interface iocts_tri_if;
   logic ddrMode;
   logic latchMode;
   logic bypass;
   logic clkHigh;
   logic clkRise;
   logic firstIn;
   logic secondIn;
   logic triOut;

   modport ctl (
      output ddrMode,
      output latchMode,
      output bypass,
      output clkHigh,
      output clkRise,
      output firstIn,
      output secondIn,
      input  triOut
   );

   modport path (
      input  ddrMode,
      input  latchMode,
      input  bypass,
      input  clkHigh,
      input  clkRise,
      input  firstIn,
      input  secondIn,
      output triOut
   );
endinterface

//--- iocts_tristate_path.sv
`timescale 1ns/1ps
module iocts_tristate_path
   import iocts_pkg::*;
(
   input wire logic   clk,
   input wire logic   rstN,
   iocts_tri_if.path  port
);

   typedef struct packed {
      logic firstReg;
      logic secondLatch;
      logic sdrStore;
   } iocts_path_type;

   iocts_path_type state_ff;
   iocts_path_type nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (port.ddrMode) begin
         if (port.clkRise) begin
            nxt_state.firstReg = port.firstIn;
         end
         // transparent while the clock is low, holds while high
         if (!port.clkHigh) begin
            nxt_state.secondLatch = port.secondIn;
         end
      end else if (port.latchMode) begin
         if (!port.clkHigh) begin
            nxt_state.sdrStore = port.firstIn;
         end
      end else if (port.clkRise) begin
         nxt_state.sdrStore = port.firstIn;
      end
   end

   always_comb begin
      if (port.bypass) begin
         port.triOut = port.firstIn;
      end else if (port.ddrMode) begin
         // first half follows the rising edge, second half the latch
         port.triOut = port.clkHigh ? state_ff.firstReg
                                    : state_ff.secondLatch;
      end else begin
         port.triOut = state_ff.sdrStore;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

endmodule

//--- iocts_top.sv
// Summary of operation
// - each cell holds two I/O elements
// - element drives data, tristate; takes pad input
// - tristate control may be registered before pad
// - one single-rate store, one rising-edge register, one latch
// - single-rate: first input via one store
// - single-rate store is flip-flop or latch
// - double-rate: first on rise, second latched
// - clock-driven mux picks stored value per phase
// - latch passes while clock low, holds high
// - move strobe-captured read data into clk domain
// - polarity selects capture edge of sync registers
// - polarity re-evaluated at every read start
// - detect undriven-to-low strobe, set polarity
`timescale 1ns/1ps
module iocts_top
   import iocts_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                ioClk,
   input  wire logic [ELEMENTS-1:0] coreDataOut,
   input  wire logic [ELEMENTS-1:0] tristateInFirst,
   input  wire logic [ELEMENTS-1:0] tristateInSecond,
   output logic      [ELEMENTS-1:0] padDataOut,
   output logic      [ELEMENTS-1:0] padTristateControl,
   input  wire logic [ELEMENTS-1:0] padDataIn,
   input  wire logic                strobeIn,
   input  wire logic                readStart,
   output logic      [ELEMENTS-1:0] readData,
   output logic                     readValid,
   output logic                     readActive,
   output logic                     clockPolarity
);

   typedef struct packed {
      logic [2:0]                ioClkSync;
      logic                      ioClkF;
      logic [2:0]                strobeSync;
      logic                      strobeF;
      logic [2:0][ELEMENTS-1:0]  dinSync;
      logic [ELEMENTS-1:0]       dinF;
      logic [CTRL_WIDTH-1:0]     ctrl;
      logic [7:0]                burstLen;
      iocts_read_type            rd;
      logic                      pol;
      logic [7:0]                beatCnt;
      logic [7:0]                waitCnt;
      logic [7:0]                detCnt;
      logic                      missFlag;
      logic [ELEMENTS-1:0]       capt;
      logic [ELEMENTS-1:0]       readData;
      logic                      readValid;
      logic                      readActive;
      logic [ELEMENTS-1:0]       padTri;
      logic [ELEMENTS-1:0]       padData;
      logic [31:0]               prdata;
      logic                      pready;
      logic                      pslverr;
   } iocts_state_type;

   logic [1:0]          rstSync_ff;
   logic                rstN;
   iocts_state_type     state_ff;
   iocts_state_type     nxt_state;
   logic                ioRise;
   logic                ioFall;
   logic                captEdge;
   logic                armReq;
   logic [7:0]          nextBeat;
   logic [7:0]          nextWait;
   logic                apbWrite;
   logic [ELEMENTS-1:0] triOut;

   // asynchronous assert, release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync_ff <= 2'h0;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end

   assign rstN = rstSync_ff[1];

   // one tristate path per element
   for (genvar g = 0; g < ELEMENTS; g++) begin : gElem
      iocts_tri_if triLink ();

      assign triLink.ddrMode   = state_ff.ctrl[CTRL_DDR_BIT];
      assign triLink.latchMode = state_ff.ctrl[CTRL_LATCH_BIT];
      assign triLink.bypass    = state_ff.ctrl[CTRL_BYPASS_BIT];
      assign triLink.clkHigh   = state_ff.ioClkF;
      assign triLink.clkRise   = ioRise;
      assign triLink.firstIn   = tristateInFirst[g];
      assign triLink.secondIn  = tristateInSecond[g];
      assign triOut[g]         = triLink.triOut;

      iocts_tristate_path uPath (
         .clk  (clk),
         .rstN (rstN),
         .port (triLink.path)
      );
   end

   always_comb begin
      nxt_state = state_ff;

      // pin inputs: three stages, a change counts once stages 2 and 3 agree
      nxt_state.ioClkSync  = {state_ff.ioClkSync[1:0], ioClk};
      nxt_state.strobeSync = {state_ff.strobeSync[1:0], strobeIn};
      nxt_state.dinSync    = {state_ff.dinSync[1:0], padDataIn};
      if (state_ff.ioClkSync[1] == state_ff.ioClkSync[2]) begin
         nxt_state.ioClkF = state_ff.ioClkSync[2];
      end
      if (state_ff.strobeSync[1] == state_ff.strobeSync[2]) begin
         nxt_state.strobeF = state_ff.strobeSync[2];
      end
      for (int i = 0; i < ELEMENTS; i++) begin
         if (state_ff.dinSync[1][i] == state_ff.dinSync[2][i]) begin
            nxt_state.dinF[i] = state_ff.dinSync[2][i];
         end
      end

      ioRise   = nxt_state.ioClkF & ~state_ff.ioClkF;
      ioFall   = ~nxt_state.ioClkF & state_ff.ioClkF;
      // selected edge of the synchronizing registers; a fall seen while
      // the link clock is high leaves too little margin to the next rise
      if (state_ff.pol) begin
         captEdge = ioFall;
      end else begin
         captEdge = ioRise;
      end
      nextBeat = state_ff.beatCnt + 8'h01;
      nextWait = state_ff.waitCnt + 8'h01;

      // pad outputs, registered once more for clean pin timing
      nxt_state.padTri  = triOut;
      nxt_state.padData = coreDataOut;

      // apb: decode in setup, answer in the first access cycle
      nxt_state.pready = psel & ~penable;
      apbWrite = psel & penable & state_ff.pready & pwrite;
      armReq   = readStart;
      if (psel && !penable) begin
         nxt_state.prdata  = 32'h0;
         nxt_state.pslverr = 1'b0;
         case (paddr)
            ADDR_CTRL: begin
               nxt_state.prdata[CTRL_WIDTH-1:0] = state_ff.ctrl;
            end
            ADDR_STATUS: begin
               nxt_state.prdata[ST_POL_BIT]    = state_ff.pol;
               nxt_state.prdata[ST_ACTIVE_BIT] = state_ff.readActive;
               nxt_state.prdata[ST_ARMED_BIT]  = state_ff.rd == RD_ARMED;
               nxt_state.prdata[ST_MISS_BIT]   = state_ff.missFlag;
               nxt_state.prdata[ST_DET_LSB +: 8]  = state_ff.detCnt;
               nxt_state.prdata[ST_BEAT_LSB +: 8] = state_ff.beatCnt;
            end
            ADDR_BURST: begin
               nxt_state.prdata[7:0] = state_ff.burstLen;
            end
            ADDR_CAPT: begin
               nxt_state.prdata[ELEMENTS-1:0] = state_ff.capt;
            end
            default: begin
               nxt_state.pslverr = 1'b1;
            end
         endcase
      end
      if (apbWrite && !state_ff.pslverr) begin
         case (paddr)
            ADDR_CTRL: begin
               nxt_state.ctrl = pwdata[CTRL_WIDTH-1:0];
               armReq = readStart | pwdata[CTRL_ARM_BIT];
            end
            ADDR_STATUS: begin
               // write one to clear; a miss in the same cycle wins below
               if (pwdata[ST_MISS_BIT]) begin
                  nxt_state.missFlag = 1'b0;
               end
            end
            ADDR_BURST: begin
               nxt_state.burstLen = pwdata[7:0];
            end
            default: begin
               nxt_state.burstLen = state_ff.burstLen;
            end
         endcase
      end

      // read capture sequencer
      nxt_state.readValid = 1'b0;
      case (state_ff.rd)
         RD_IDLE: begin
            // a new arm starts a fresh polarity decision
            if (armReq) begin
               nxt_state.rd      = RD_ARMED;
               nxt_state.waitCnt = 8'h00;
            end
         end
         RD_ARMED: begin
            // strobe must be seen at its undriven high level first
            if (state_ff.strobeF && !nxt_state.strobeF) begin
               // falling mid-high: the next rise is too close, use fall
               nxt_state.pol        = state_ff.ioClkF;
               nxt_state.detCnt     = state_ff.detCnt + 8'h01;
               nxt_state.beatCnt    = 8'h00;
               nxt_state.rd         = RD_BURST;
               nxt_state.readActive = 1'b1;
            end else if (ioRise) begin
               nxt_state.waitCnt = nextWait;
               if (nextWait >= PREAMBLE_WAIT_EDGES) begin
                  nxt_state.missFlag = 1'b1;
                  nxt_state.rd       = RD_IDLE;
               end
            end
         end
         RD_BURST: begin
            // polarity is left alone until the burst ends
            if (captEdge) begin
               nxt_state.capt      = state_ff.dinF;
               nxt_state.readData  = state_ff.dinF;
               nxt_state.readValid = 1'b1;
               nxt_state.beatCnt   = nextBeat;
               if (nextBeat >= state_ff.burstLen) begin
                  nxt_state.rd         = RD_IDLE;
                  nxt_state.readActive = 1'b0;
               end
            end
         end
         default: begin
            nxt_state.rd         = RD_IDLE;
            nxt_state.readActive = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_ff          <= '0;
         state_ff.ctrl     <= CTRL_RESET;
         state_ff.burstLen <= BURST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign prdata             = state_ff.prdata;
   assign pready             = state_ff.pready;
   assign pslverr            = state_ff.pslverr;
   assign padDataOut         = state_ff.padData;
   assign padTristateControl = state_ff.padTri;
   assign readData           = state_ff.readData;
   assign readValid          = state_ff.readValid;
   assign readActive         = state_ff.readActive;
   assign clockPolarity      = state_ff.pol;

endmodule

//--- iocts_top_props.sv
`timescale 1ns/1ps
module iocts_top_chk
   import iocts_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst_b,
   input wire logic [11:0]         paddr,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   input wire logic [ELEMENTS-1:0] coreDataOut,
   input wire logic [ELEMENTS-1:0] tristateInFirst,
   input wire logic [ELEMENTS-1:0] padDataOut,
   input wire logic [ELEMENTS-1:0] padTristateControl,
   input wire logic                strobeIn,
   input wire logic                readValid,
   input wire logic                readActive,
   input wire logic                clockPolarity
);
   logic [2:0] ctrlShadow_ff;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // shadow of the mode bits, so the bypass check knows the mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         ctrlShadow_ff <= CTRL_RESET;
      else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
         ctrlShadow_ff <= pwdata[2:0];
   end

   sequence sSetup;
      psel && !penable;
   endsequence

   chk_ready_once: assert property (sSetup |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   chk_data_delay: assert property (padDataOut == $past(coreDataOut))
      else $error("pad data not one cycle behind core data");
   chk_bypass_path: assert property (ctrlShadow_ff[CTRL_BYPASS_BIT]
      && $past(ctrlShadow_ff[CTRL_BYPASS_BIT])
      |-> padTristateControl == $past(tristateInFirst))
      else $error("bypass tristate not following first input");
   chk_pol_hold: assert property (readActive && $past(readActive)
      |-> $stable(clockPolarity))
      else $error("polarity moved inside a burst");
   chk_pol_start: assert property ($changed(clockPolarity)
      |-> $rose(readActive))
      else $error("polarity changed outside a read start");
   chk_valid_pulse: assert property (readValid |=> !readValid)
      else $error("capture strobe longer than one cycle");
   chk_valid_burst: assert property (readValid |-> $past(readActive))
      else $error("capture outside a burst");
   chk_detect_low: assert property ($rose(readActive)
      |-> !$past(strobeIn, 2))
      else $error("burst started without strobe driven low");
endmodule

//--- iocts_ddr_mem.sv
`timescale 1ns/1ps
module iocts_ddr_mem
   import iocts_pkg::*;
(
   input  wire logic                ioClk,
   input  wire logic                go,
   input  wire logic                onHigh,
   input  wire logic [ELEMENTS-1:0] word,
   output logic      [ELEMENTS-1:0] padDataIn,
   output logic                     strobeIn
);
   initial begin
      strobeIn = 1'b1;
      padDataIn = 2'h0;
      forever begin
         @(posedge go);
         // the phase of the fall picks the polarity the device must find
         if (onHigh)
            @(posedge ioClk);
         else
            @(negedge ioClk);
         #40;
         strobeIn = 1'b0;
         padDataIn = word;
         repeat (24) begin
            @(ioClk);
            #40;
            strobeIn = ~strobeIn;
         end
         strobeIn = 1'b1;
         padDataIn = ~word;
      end
   end
endmodule

//--- tb_iocts_top.sv
`timescale 1ns/1ps
module tb_iocts_top
   import iocts_pkg::*;
;
   logic                clk = 1'b0, rst_b = 1'b0, ioClk = 1'b0;
   logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                readStart = 1'b0, go = 1'b0, onHigh = 1'b0;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h0, prdata, rdq;
   logic                pready, pslverr, rde, strobeIn;
   logic                readValid, readActive, clockPolarity;
   logic [ELEMENTS-1:0] coreDataOut = 2'h0, tristateInFirst = 2'h0;
   logic [ELEMENTS-1:0] tristateInSecond = 2'h0, word = 2'h0;
   logic [ELEMENTS-1:0] padDataOut, padTristateControl, padDataIn, readData;
   int                  miscompares = 0, compares = 0, beats = 0;

   iocts_top u_dut (.*);
   iocts_ddr_mem u_mem (.*);

   always #4 clk = ~clk;
   initial begin
      #3;
      forever #80 ioClk = ~ioClk;
   end

   task automatic cmpw(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmpv(input string n, input logic [1:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers is a failure, not a silent pass
      if (pready !== 1'b1)
         miscompares++;
      rdq = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // drive mid-phase, check before the synced phase flips
   task automatic step(input logic hi, input logic [1:0] f, s, e);
      if (hi)
         @(posedge ioClk);
      else
         @(negedge ioClk);
      repeat (6) @(posedge clk);
      tristateInFirst <= f;
      tristateInSecond <= s;
      repeat (3) @(posedge clk);
      #1 cmpv("padTri", e, padTristateControl);
   endtask

   task automatic waitact(input logic v, input int lim);
      int k;
      k = 0;
      while (readActive !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
      if (k >= lim)
         miscompares++;
   endtask

   task automatic rdburst(input logic [7:0] n, input logic h,
                          input logic [1:0] w);
      apb(1'b1, ADDR_BURST, {24'h0, n});
      onHigh <= h;
      word <= w;
      beats = 0;
      @(posedge clk) readStart <= 1'b1;
      @(posedge clk) readStart <= 1'b0;
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      waitact(1'b1, 400);
      #1 cmpv("pol", {1'b0, h}, {1'b0, clockPolarity});
      waitact(1'b0, 1000);
      // last beat's valid is counted one edge after active falls
      @(posedge clk);
      cmpw("beats", (n == 8'h0) ? 32'h1 : {24'h0, n}, beats);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmpw("stPol", {31'h0, h}, rdq & 32'h1);
      cmpw("stBeat", (n == 8'h0) ? 32'h1 : {24'h0, n},
           (rdq >> ST_BEAT_LSB) & 32'hff);
      apb(1'b0, ADDR_CAPT, 32'h0);
      cmpw("capt", {30'h0, w}, rdq);
      // let the memory finish toggling so no stray fall arms next read
      repeat (300) @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (readValid === 1'b1) begin
         beats++;
         cmpv("rdData", word, readData);
      end
   end

   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      end_of_test;
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, ADDR_CTRL, 32'h0);
      cmpw("ctrl", {29'h0, CTRL_RESET}, rdq);
      apb(1'b0, ADDR_BURST, 32'h0);
      cmpw("burst", {24'h0, BURST_RESET}, rdq);
      apb(1'b0, 12'h010, 32'h0);
      cmpw("unmapped", 32'h1, {31'h0, rde});
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) coreDataOut <= i[1:0];
         @(posedge clk) #1 cmpv("padData", i[1:0], padDataOut);
      end
      $display("data path done");
      apb(1'b1, ADDR_CTRL, 32'h4);
      step(1'b1, 2'h1, 2'h0, 2'h1);
      step(1'b0, 2'h2, 2'h0, 2'h2);
      apb(1'b1, ADDR_CTRL, 32'h0);
      step(1'b1, 2'h3, 2'h0, 2'h2);
      step(1'b0, 2'h1, 2'h0, 2'h2);
      step(1'b1, 2'h2, 2'h0, 2'h1);
      apb(1'b1, ADDR_CTRL, 32'h2);
      step(1'b1, 2'h3, 2'h0, 2'h2);
      step(1'b0, 2'h1, 2'h0, 2'h1);
      step(1'b1, 2'h3, 2'h0, 2'h1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      step(1'b0, 2'h2, 2'h1, 2'h1);
      step(1'b1, 2'h3, 2'h2, 2'h2);
      step(1'b0, 2'h1, 2'h3, 2'h3);
      step(1'b1, 2'h0, 2'h0, 2'h1);
      $display("tristate done");
      rdburst(8'h3, 1'b0, 2'h2);
      rdburst(8'h8, 1'b1, 2'h1);
      rdburst(8'h0, 1'b0, 2'h3);
      $display("reads done");
      apb(1'b1, ADDR_CTRL, 32'h8);
      repeat (1400) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmpw("miss", 32'h8, rdq & 32'hc);
      apb(1'b1, ADDR_STATUS, 32'h8);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmpw("missClr", 32'h0, rdq & 32'h8);
      $display("missed preamble done");
      end_of_test;
   end
endmodule

bind iocts_top iocts_top_chk u_chk (.*);
